/* design/tx_system_side_interface.sv */
// Transmit system-side interface: pin multiplexing, sampling, indication, clock-loss reset
//
// Behaviour
// - Single NRZ and dual RZ modes turn the shared negative pin into indication output.
// - Config bits 7..5 choose which status drives the indication output.
// - Indication output updates on the selected channel clock edge when clock present.
// - Indication output is always active high, never inverted by data polarity.
// - Data rails are sampled on the clock edge chosen by config bit 4.
// - Dual RZ mode uses no clock; clock pin becomes negative data input.
// - Config bit 3 sets the active level of both data rails.
// - Master clock lost (duty under 30% for 10 us) then recovered causes auto reset.
`timescale 1ns/1ps
`default_nettype none
module tx_system_side_interface #(
    parameter int LOSS_CYCLES = tx_sys_pkg::LOSS_CYCLES
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [tx_sys_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic tx_positive_rail_i,
    input wire logic tx_channel_clock_i,
    input wire logic tx_negative_rail_i,
    output logic tx_indication_out_o,
    output logic tx_indication_oe_n_o,
    input wire tx_sys_pkg::ind_sources_t sources_i,
    input wire logic master_clock_i,
    input wire logic [3:0] master_clock_select_i,
    output tx_sys_pkg::rail_data_t rail_o,
    output logic self_reset_o,
    output logic irq_o
);
    localparam int DUTY_LIMIT = tx_sys_pkg::DUTY_WINDOW * tx_sys_pkg::DUTY_MIN_PCT / 100;

    logic [7:0] tx_config_one;
    tx_sys_pkg::rail_mode_t mode;
    logic [tx_sys_pkg::ST_BITS-1:0] status;
    logic [tx_sys_pkg::ST_BITS-1:0] irq_mask;
    logic [2:0] pos_sync, neg_sync, clk_sync, mck_sync;
    logic clk_prev;
    logic [3:0] mck_sel;
    logic clk_lost;
    logic reset_pulse;
    logic [15:0] reset_hold;

    function automatic logic sel_source(input logic [2:0] sel, input tx_sys_pkg::ind_sources_t s);
        logic r;
        r = 1'b0;
        unique case (sel)
            tx_sys_pkg::IND_PATTERN: r = s.pattern;
            tx_sys_pkg::IND_ALARM: r = s.alarm;
            tx_sys_pkg::IND_OVERCURRENT: r = s.overcurrent;
            tx_sys_pkg::IND_TX_LOSS: r = s.tx_loss;
            tx_sys_pkg::IND_EXZ: r = s.exz;
            tx_sys_pkg::IND_BPV: r = s.bpv;
            tx_sys_pkg::IND_EXZ_BPV: r = s.exz | s.bpv;
            tx_sys_pkg::IND_LOS: r = s.los;
        endcase
        return r;
    endfunction

    // Two-flop synchronisers; third stage feeds edge and level logic
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pos_sync <= 3'h0;
            neg_sync <= 3'h0;
            clk_sync <= 3'h0;
            mck_sync <= 3'h0;
            clk_prev <= 1'b0;
        end
        else
        begin
            pos_sync <= {pos_sync[1:0], tx_positive_rail_i};
            neg_sync <= {neg_sync[1:0], tx_negative_rail_i};
            clk_sync <= {clk_sync[1:0], tx_channel_clock_i};
            mck_sync <= {mck_sync[1:0], master_clock_i};
            clk_prev <= clk_sync[2];
        end
    end

    logic clk_rise, clk_fall, active_edge, pol;
    assign clk_rise = clk_sync[2] & ~clk_prev;
    assign clk_fall = ~clk_sync[2] & clk_prev;
    assign active_edge = tx_config_one[tx_sys_pkg::EDGE_SEL_BIT] ? clk_fall : clk_rise;
    assign pol = tx_config_one[tx_sys_pkg::INVERT_BIT];

    // Register writes
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_config_one <= tx_sys_pkg::CONFIG_ONE_RESET;
            mode <= tx_sys_pkg::MODE_SINGLE_NRZ;
            irq_mask <= '0;
        end
        else if (reset_pulse)
        begin
            tx_config_one <= tx_sys_pkg::CONFIG_ONE_RESET;
            mode <= tx_sys_pkg::MODE_SINGLE_NRZ;
            irq_mask <= '0;
        end
        else if (wr_i)
        begin
            unique case (addr_i)
                tx_sys_pkg::ADDR_CONFIG_ONE: tx_config_one <= wdata_i;
                tx_sys_pkg::ADDR_MODE:
                    mode <= (wdata_i[1:0] == 2'h1) ? tx_sys_pkg::MODE_DUAL_NRZ :
                            (wdata_i[1:0] == 2'h2) ? tx_sys_pkg::MODE_DUAL_RZ :
                            tx_sys_pkg::MODE_SINGLE_NRZ;
                tx_sys_pkg::ADDR_IRQ_MASK: irq_mask <= wdata_i[tx_sys_pkg::ST_BITS-1:0];
                default: ;
            endcase
        end
    end

    // Register reads, data one cycle after strobe
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_o <= 8'h00;
        else if (rd_i)
        begin
            unique case (addr_i)
                tx_sys_pkg::ADDR_CONFIG_ONE: rdata_o <= tx_config_one;
                tx_sys_pkg::ADDR_MODE: rdata_o <= {6'h00, mode};
                tx_sys_pkg::ADDR_STATUS: rdata_o <= {6'h00, status};
                tx_sys_pkg::ADDR_IRQ_MASK: rdata_o <= {6'h00, irq_mask};
                default: rdata_o <= 8'h00;
            endcase
        end
        else
            rdata_o <= 8'h00;
    end

    // Rail sampling per mode
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rail_o <= '0;
        else
        begin
            rail_o.valid <= 1'b0;
            unique case (mode)
                tx_sys_pkg::MODE_SINGLE_NRZ:
                    if (active_edge)
                    begin
                        rail_o <= '{pos: pos_sync[2] ^ pol, neg: 1'b0, valid: 1'b1};
                    end
                tx_sys_pkg::MODE_DUAL_NRZ:
                    if (active_edge)
                    begin
                        rail_o <= '{pos: pos_sync[2] ^ pol, neg: neg_sync[2] ^ pol,
                                    valid: 1'b1};
                    end
                tx_sys_pkg::MODE_DUAL_RZ:
                    // Clock pin carries the negative rail; levels pass through
                    rail_o <= '{pos: pos_sync[2] ^ pol, neg: clk_sync[2] ^ pol,
                                valid: 1'b1};
            endcase
        end
    end

    // Indication output and its pin direction
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_indication_out_o <= 1'b0;
            tx_indication_oe_n_o <= 1'b1;
        end
        else
        begin
            tx_indication_oe_n_o <= (mode == tx_sys_pkg::MODE_DUAL_NRZ);
            if (mode == tx_sys_pkg::MODE_DUAL_RZ)
                // No channel clock here, so follow the source directly
                tx_indication_out_o <= sel_source(tx_config_one[tx_sys_pkg::IND_SEL_HI:
                    tx_sys_pkg::IND_SEL_LO], sources_i);
            else if (active_edge)
                tx_indication_out_o <= sel_source(tx_config_one[tx_sys_pkg::IND_SEL_HI:
                    tx_sys_pkg::IND_SEL_LO], sources_i);
        end
    end

    // Master clock duty monitor: high time over back-to-back fixed windows of DUTY_WINDOW cycles
    logic [7:0] win_cnt, high_cnt;
    logic [15:0] low_duty_cnt;
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            win_cnt <= 8'h00;
            high_cnt <= 8'h00;
            low_duty_cnt <= 16'h0000;
            clk_lost <= 1'b0;
            mck_sel <= 4'h0;
        end
        else
        begin
            mck_sel <= master_clock_select_i;
            if (win_cnt == 8'(tx_sys_pkg::DUTY_WINDOW - 1))
            begin
                win_cnt <= 8'h00;
                high_cnt <= 8'h00;
                // Duty of either level under the minimum counts as missing
                if ((high_cnt < 8'(DUTY_LIMIT)) ||
                    (high_cnt > 8'(tx_sys_pkg::DUTY_WINDOW - DUTY_LIMIT)))
                begin
                    if (low_duty_cnt + 16'(tx_sys_pkg::DUTY_WINDOW) >= 16'(LOSS_CYCLES))
                        clk_lost <= 1'b1;
                    else
                        low_duty_cnt <= low_duty_cnt + 16'(tx_sys_pkg::DUTY_WINDOW);
                end
                else
                begin
                    low_duty_cnt <= 16'h0000;
                    clk_lost <= 1'b0;
                end
            end
            else
            begin
                win_cnt <= win_cnt + 8'h01;
                high_cnt <= high_cnt + {7'h00, mck_sync[2]};
            end
        end
    end

    // Automatic reset on recovery after loss
    logic lost_prev;
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            lost_prev <= 1'b0;
            reset_pulse <= 1'b0;
            reset_hold <= 16'h0000;
            self_reset_o <= 1'b0;
        end
        else
        begin
            lost_prev <= clk_lost;
            reset_pulse <= lost_prev & ~clk_lost;
            if (lost_prev & ~clk_lost)
                reset_hold <= 16'(tx_sys_pkg::RESET_HOLD_CYCLES);
            else if (reset_hold != 16'h0000)
                reset_hold <= reset_hold - 16'h0001;
            self_reset_o <= (lost_prev & ~clk_lost) || (reset_hold > 16'h0001);
        end
    end

    // Sticky status, write one to clear, set wins
    logic [tx_sys_pkg::ST_BITS-1:0] set_bits, clr_bits;
    always_comb
    begin
        set_bits = '0;
        set_bits[tx_sys_pkg::ST_CLK_LOST] = clk_lost & ~lost_prev;
        set_bits[tx_sys_pkg::ST_AUTO_RESET] = reset_pulse;
        clr_bits = (wr_i && addr_i == tx_sys_pkg::ADDR_STATUS) ?
                   wdata_i[tx_sys_pkg::ST_BITS-1:0] : '0;
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            status <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            status <= (status & ~clr_bits) | set_bits;
            irq_o <= |(((status & ~clr_bits) | set_bits) & irq_mask);
        end
    end
endmodule
`default_nettype wire

/* shared/tx_sys_pkg.sv */
// Package for the transmit system-side interface: modes, fields, timing
package tx_sys_pkg;
    typedef enum logic [1:0] {
        MODE_SINGLE_NRZ,
        MODE_DUAL_NRZ,
        MODE_DUAL_RZ
    } rail_mode_t;

    // Indication source encodings
    localparam logic [2:0] IND_PATTERN = 3'h0;
    localparam logic [2:0] IND_ALARM = 3'h1;
    localparam logic [2:0] IND_OVERCURRENT = 3'h2;
    localparam logic [2:0] IND_TX_LOSS = 3'h3;
    localparam logic [2:0] IND_EXZ = 3'h4;
    localparam logic [2:0] IND_BPV = 3'h5;
    localparam logic [2:0] IND_EXZ_BPV = 3'h6;
    localparam logic [2:0] IND_LOS = 3'h7;

    // Register map (word offsets as byte addresses)
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_CONFIG_ONE = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

    // tx_config_one fields
    localparam int IND_SEL_HI = 7;
    localparam int IND_SEL_LO = 5;
    localparam int EDGE_SEL_BIT = 4;
    localparam int INVERT_BIT = 3;
    localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;

    // Interrupt status bits
    localparam int ST_CLK_LOST = 0;
    localparam int ST_AUTO_RESET = 1;
    localparam int ST_BITS = 2;

    // Master clock loss: duty below 30 percent for 10 us
    localparam int CLK_PERIOD_NS = 40;
    localparam int LOSS_TIME_NS = 10000;
    localparam int LOSS_CYCLES = LOSS_TIME_NS / CLK_PERIOD_NS;
    localparam int DUTY_MIN_PCT = 30;
    localparam int DUTY_WINDOW = 100;
    localparam int RESET_HOLD_CYCLES = 16;

    typedef struct packed {
        logic pattern;
        logic alarm;
        logic overcurrent;
        logic tx_loss;
        logic exz;
        logic bpv;
        logic los;
    } ind_sources_t;

    typedef struct packed {
        logic pos;
        logic neg;
        logic valid;
    } rail_data_t;
endpackage

/* dv/tx_sys_checker_assertions.sv */
// Port checker for the transmit system-side interface
`timescale 1ns/1ps
`default_nettype none
module tx_sys_checker #(
    parameter int LOSS_CYCLES = 250
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [3:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic tx_channel_clock_i,
    input wire logic tx_indication_out_o,
    input wire logic tx_indication_oe_n_o,
    input wire tx_sys_pkg::ind_sources_t sources_i,
    input wire tx_sys_pkg::rail_data_t rail_o,
    input wire logic self_reset_o,
    input wire logic irq_o
);
    wire logic mode_wr = wr_i && addr_i == tx_sys_pkg::ADDR_MODE;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    a_unmapped_read: assert property (rd_i && addr_i[1:0] != 2'h0 |=> rdata_o == 8'h00)
        else $error("unmapped read gave data");
    a_nrz_pulse: assert property (tx_indication_oe_n_o && rail_o.valid |=> !rail_o.valid)
        else $error("sample strobe longer than one cycle");
    a_no_edge_idle: assert property ((tx_indication_oe_n_o && $stable(tx_channel_clock_i))[*8]
        |=> !rail_o.valid)
        else $error("sample without clock edge");
    a_ind_low: assert property ((sources_i == 7'h00)[*8] ##0
        (rail_o.valid && !tx_indication_oe_n_o) |-> !tx_indication_out_o)
        else $error("indication high with no source");
    a_ind_high: assert property ((sources_i == 7'h7f)[*8] ##0
        (rail_o.valid && !tx_indication_oe_n_o) |-> tx_indication_out_o)
        else $error("indication low with all sources");
    a_irq_fall: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2)
        || self_reset_o || $past(self_reset_o) || $past(self_reset_o, 2))
        else $error("interrupt dropped without cause");
    a_oe_mode: assert property ($changed(tx_indication_oe_n_o) |-> $past(mode_wr)
        || $past(mode_wr, 2) || !$past(rstn_i) || !$past(rstn_i, 2) || self_reset_o)
        else $error("pin direction changed without mode write");
    c_self_reset: cover property ($rose(self_reset_o));
    c_irq: cover property ($rose(irq_o));
    c_dual_sample: cover property (tx_indication_oe_n_o && rail_o.valid);
endmodule
bind tx_system_side_interface tx_sys_checker #(.LOSS_CYCLES(LOSS_CYCLES)) chk (
    .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .tx_channel_clock_i(tx_channel_clock_i),
    .tx_indication_out_o(tx_indication_out_o), .tx_indication_oe_n_o(tx_indication_oe_n_o),
    .sources_i(sources_i), .rail_o(rail_o), .self_reset_o(self_reset_o), .irq_o(irq_o)
);
`default_nettype wire

/* dv/tx_framer_model.sv */
// Framer model driving the channel clock and transmit rails
`timescale 1ns/1ps
`default_nettype none
module tx_framer_model (
    input wire logic run_i,
    input wire logic fall_i,
    output logic lclk_o,
    output logic pos_o,
    output logic neg_o
);
    bit qp[$];
    bit qn[$];
    task automatic push;
        qp.push_back(pos_o);
        qn.push_back(neg_o);
    endtask
    initial
    begin
        {lclk_o, pos_o, neg_o} = 3'b000;
        #13;
        forever
        begin
            if (run_i)
            begin
                lclk_o = 1'b1;
                if (!fall_i)
                    push();
                #80;
                {pos_o, neg_o} = 2'($urandom);
                #80;
                lclk_o = 1'b0;
                if (fall_i)
                    push();
                #160;
            end
            else
            begin
                #40;
                {pos_o, neg_o} = ~{pos_o, neg_o};
            end
        end
    end
endmodule
`default_nettype wire

/* dv/tx_system_side_interface_test.sv */
// Self-checking bench for the transmit system-side interface
`timescale 1ns/1ps
`default_nettype none
module tx_system_side_interface_test;
    logic clock_i, rstn_i, wr, rd, mclk, mrun, run, fall, rz, rz_p, rz_n, nrz, inv;
    logic ind, oe_n, self_rst, irq, lclk, fpos, fneg;
    logic [3:0] addr, msel;
    logic [7:0] wdata, rdata;
    tx_sys_pkg::ind_sources_t src;
    tx_sys_pkg::rail_data_t rail;
    int bad_count = 0;
    int checks = 0;
    int n;
    bit p, q;
    tx_system_side_interface #(.LOSS_CYCLES(50)) DUT (
        .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .tx_positive_rail_i(rz ? rz_p : fpos),
        .tx_channel_clock_i(rz ? rz_n : lclk), .tx_negative_rail_i(oe_n ? fneg : ind),
        .tx_indication_out_o(ind), .tx_indication_oe_n_o(oe_n), .sources_i(src),
        .master_clock_i(mclk), .master_clock_select_i(msel), .rail_o(rail),
        .self_reset_o(self_rst), .irq_o(irq));
    tx_framer_model far (.run_i(run), .fall_i(fall), .lclk_o(lclk), .pos_o(fpos), .neg_o(fneg));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp({7'h00, got}, {7'h00, exp});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic guard(input int got, input int lim);
        if (got >= lim)
        begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clock_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock_i);
        {addr, rd} <= {a, 1'b1};
        @(posedge clock_i);
        rd <= 1'b0;
        #1;
        cmp(rdata, e);
    endtask
    function automatic logic pick(input logic [2:0] s, input tx_sys_pkg::ind_sources_t v);
        case (s)
            tx_sys_pkg::IND_PATTERN: return v.pattern;
            tx_sys_pkg::IND_ALARM: return v.alarm;
            tx_sys_pkg::IND_OVERCURRENT: return v.overcurrent;
            tx_sys_pkg::IND_TX_LOSS: return v.tx_loss;
            tx_sys_pkg::IND_EXZ: return v.exz;
            tx_sys_pkg::IND_BPV: return v.bpv;
            tx_sys_pkg::IND_EXZ_BPV: return v.exz | v.bpv;
            default: return v.los;
        endcase
    endfunction
    initial
    begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    always @(posedge clock_i)
        mclk <= mrun ? ~mclk : 1'b0;
    always @(posedge clock_i)
        if (nrz && rail.valid)
        begin
            p = far.qp.pop_front();
            q = far.qn.pop_front();
            cmp1(rail.pos, p ^ inv);
            if (oe_n)
                cmp1(rail.neg, q ^ inv);
        end
    initial
    begin
        {rstn_i, wr, rd, mclk, run, fall, rz, rz_p, rz_n, nrz, inv} = '0;
        {mrun, addr, wdata, src} = {1'b1, 19'h0_0000};
        msel = 4'h0;
        void'($urandom(36));
        repeat (16) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd_reg(tx_sys_pkg::ADDR_CONFIG_ONE, tx_sys_pkg::CONFIG_ONE_RESET);
        rd_reg(4'h2, 8'h00);
        wr_reg(tx_sys_pkg::ADDR_MODE, 8'h02);
        rz <= 1'b1;
        for (int k = 0; k < 16; k++)
        begin
            inv <= k[3];
            src <= 7'($urandom);
            {rz_p, rz_n} <= 2'($urandom);
            wr_reg(tx_sys_pkg::ADDR_CONFIG_ONE, {k[2:0], 1'b0, k[3], 3'h0});
            repeat (8) @(posedge clock_i);
            #1;
            cmp1(ind, pick(k[2:0], src));
            cmp1(oe_n, 1'b0);
            cmp({6'h00, rail.pos, rail.neg}, {6'h00, rz_p ^ inv, rz_n ^ inv});
            @(posedge clock_i);
        end
        {rz, rz_p, rz_n} <= 3'b000;
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(tx_sys_pkg::ADDR_MODE, {7'h00, k[1]});
            rd_reg(tx_sys_pkg::ADDR_MODE, {7'h00, k[1]});
            wr_reg(tx_sys_pkg::ADDR_CONFIG_ONE, {3'h5, k[0], k[0], 3'h0});
            {src, inv, fall} <= {k[0] ? 7'h00 : 7'h7f, k[0], k[0]};
            repeat (10) @(posedge clock_i);
            {nrz, run} <= 2'b11;
            repeat (80) @(posedge clock_i);
            run <= 1'b0;
            repeat (20) @(posedge clock_i);
            nrz <= 1'b0;
            cmp(8'(far.qp.size()), 8'h00);
            cmp1(oe_n, k[1]);
            if (!k[1])
                cmp1(ind, !k[0]);
            far.qp.delete();
            far.qn.delete();
        end
        wr_reg(tx_sys_pkg::ADDR_IRQ_MASK, 8'h01);
        rd_reg(tx_sys_pkg::ADDR_IRQ_MASK, 8'h01);
        wr_reg(tx_sys_pkg::ADDR_CONFIG_ONE, 8'hf8);
        mrun <= 1'b0;
        for (n = 0; n < 1000 && irq !== 1'b1; n++)
            @(posedge clock_i);
        guard(n, 1000);
        wr_reg(tx_sys_pkg::ADDR_IRQ_MASK, 8'h00);
        repeat (2) @(posedge clock_i);
        #1;
        cmp1(irq, 1'b0);
        @(posedge clock_i);
        mrun <= 1'b1;
        for (n = 0; n < 2000 && self_rst !== 1'b1; n++)
            @(posedge clock_i);
        guard(n, 2000);
        repeat (40) @(posedge clock_i);
        rd_reg(tx_sys_pkg::ADDR_CONFIG_ONE, 8'h00);
        rd_reg(tx_sys_pkg::ADDR_STATUS, 8'h03);
        rd_reg(tx_sys_pkg::ADDR_MODE, 8'h00);
        rd_reg(tx_sys_pkg::ADDR_IRQ_MASK, 8'h00);
        wr_reg(tx_sys_pkg::ADDR_STATUS, 8'h03);
        rd_reg(tx_sys_pkg::ADDR_STATUS, 8'h00);
        wr_reg(tx_sys_pkg::ADDR_MODE, 8'h03);
        rd_reg(tx_sys_pkg::ADDR_MODE, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
